/* File: rtl/flash_erase_map.svh */
// constants of the serial flash erase controller
`ifndef FLASH_ERASE_MAP_SVH
`define FLASH_ERASE_MAP_SVH

// opcodes
`define OP_WRITE_ENABLE 8'h06
`define OP_WRITE_DISABLE 8'h04
`define OP_BULK_ERASE 8'hC7
`define OP_SECTOR_ERASE 8'hD8
`define OP_SUBSECTOR_ERASE 8'h20
`define OP_READ_BYTES 8'h03
`define OP_FAST_READ 8'h0B
`define OP_DUAL_READ 8'hBB
`define OP_QUAD_READ 8'hEB
`define OP_READ_ID 8'h9F
`define OP_READ_STATUS 8'h05

// frame lengths in serial clock edges
`define OPCODE_BITS 6'h08
`define ADDR3_FRAME_BITS 6'h20
`define ADDR4_FRAME_BITS 6'h28
`define BIT_COUNT_MAX 6'h3F

// address masks
`define ADDR3_MASK 32'h00FF_FFFF
`define SECTOR_MASK 32'hFFFF_0000
`define SUBSECTOR_MASK 32'hFFFF_F000

// erase cycle times in ms and the system clock rate in kHz
`define CLK_FREQ_KHZ 25000
`define WHOLE_ERASE_CYCLE_TIME_MS 30000
`define SECTOR_ERASE_CYCLE_TIME_MS 700
`define SUBSECTOR_ERASE_CYCLE_TIME_MS 300

`endif

/* File: rtl/flash_erase_pkg.sv */
// types of the serial flash erase controller
package flash_erase_pkg;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h1,
        ST_ERASE = 2'h2
    } erase_state_t;

    typedef enum logic [1:0] {
        SCOPE_BULK = 2'h0,
        SCOPE_SECTOR = 2'h1,
        SCOPE_SUBSECTOR = 2'h2
    } erase_scope_t;

    typedef struct packed {
        logic [5:0] bits;
        logic [7:0] opcode;
        logic [31:0] addr;
    } link_state_t;

    typedef struct packed {
        logic cs_s1;
        logic cs_s2;
        logic cs_d;
        erase_state_t state;
        logic wel;
        logic wip;
        logic active;
        logic start;
        logic commit;
        logic refused;
        erase_scope_t scope;
        logic [31:0] base;
        logic [31:0] timer;
    } ctrl_state_t;

endpackage : flash_erase_pkg

/* File: rtl/serial_cmd_shifter.sv */
// serial-clock side: shifts opcode and address in from the link
`timescale 1ns/10ps
`include "flash_erase_map.svh"

module serial_cmd_shifter
    import flash_erase_pkg::*;
(
    input wire logic serial_clock,
    input wire logic chip_select_n,
    input wire logic serial_data_in_line,
    output logic [5:0] frame_bits,
    output logic [7:0] frame_opcode,
    output logic [31:0] frame_addr
);

    link_state_t q;
    link_state_t d;
    logic fresh_r;
    logic [5:0] cnt_base;
    logic [7:0] op_base;

    // marks the first edge of each frame; set while deselected
    always_ff @(posedge serial_clock or posedge chip_select_n) begin
        if (chip_select_n) begin
            fresh_r <= 1'b1;
        end else begin
            fresh_r <= 1'b0;
        end
    end

    always_comb begin
        d = q;
        cnt_base = fresh_r ? 6'h00 : q.bits;
        op_base = fresh_r ? 8'h00 : q.opcode;
        if (cnt_base < `OPCODE_BITS) begin
            d.opcode = {op_base[6:0], serial_data_in_line};
        end else begin
            d.addr = {q.addr[30:0], serial_data_in_line};
        end
        if (cnt_base != `BIT_COUNT_MAX) begin
            d.bits = cnt_base + 6'h01;
        end else begin
            d.bits = cnt_base;
        end
    end

    // values hold while the link clock stands still after a frame
    always_ff @(posedge serial_clock) begin
        q <= d;
    end

    assign frame_bits = q.bits;
    assign frame_opcode = q.opcode;
    assign frame_addr = q.addr;

endmodule : serial_cmd_shifter

/* File: rtl/serial_flash_erase_control.sv */
// erase command control: write enable latch, self-timed erase, power mode
// Notes on behaviour
// - whole-array erase C7h sets every bit
// - bulk erase starts when select rises
// - busy bit one during erase, then zero
// - write enable latch cleared before completion
// - sector erase D8h fills addressed sector
// - any address inside selects whole sector
// - sector erase starts when select rises
// - subsector erase fills addressed subsector
// - subsector erase starts when select rises
// - four-byte mode carries 32-bit address
// - selected device is in active power
// - active until internal cycle ends, then standby
// - sector erase lasts its cycle time
// - read during erase ignored, erase continues
`timescale 1ns/10ps
`include "flash_erase_map.svh"

module serial_flash_erase_control
    import flash_erase_pkg::*;
#(
    parameter int unsigned WHOLE_ERASE_CYCLES =
        `WHOLE_ERASE_CYCLE_TIME_MS * `CLK_FREQ_KHZ,
    parameter int unsigned SECTOR_ERASE_CYCLES =
        `SECTOR_ERASE_CYCLE_TIME_MS * `CLK_FREQ_KHZ,
    parameter int unsigned SUBSECTOR_ERASE_CYCLES =
        `SUBSECTOR_ERASE_CYCLE_TIME_MS * `CLK_FREQ_KHZ
)
(
    input wire logic clk,
    input wire logic reset,
    input wire logic serial_clock,
    input wire logic chip_select_n,
    input wire logic serial_data_in_line,
    input wire logic addr_four_byte,
    output logic wip_r,
    output logic wel_r,
    output logic active_power_r,
    output logic erase_start_r,
    output logic erase_commit_r,
    output logic [1:0] erase_scope_r,
    output logic [31:0] erase_base_r,
    output logic read_refused_r
);

    localparam ctrl_state_t RESET_STATE = '{
        cs_s1: 1'b1,
        cs_s2: 1'b1,
        cs_d: 1'b1,
        state: ST_IDLE,
        wel: 1'b0,
        wip: 1'b0,
        active: 1'b0,
        start: 1'b0,
        commit: 1'b0,
        refused: 1'b0,
        scope: SCOPE_BULK,
        base: 32'h0000_0000,
        timer: 32'h0000_0000
    };

    ctrl_state_t q;
    ctrl_state_t d;
    logic [5:0] frame_bits;
    logic [7:0] frame_opcode;
    logic [31:0] frame_addr;
    logic frame_end;
    logic [31:0] eff_addr;

    serial_cmd_shifter u_shifter (
        .serial_clock(serial_clock),
        .chip_select_n(chip_select_n),
        .serial_data_in_line(serial_data_in_line),
        .frame_bits(frame_bits),
        .frame_opcode(frame_opcode),
        .frame_addr(frame_addr)
    );

    function automatic logic is_erase_op(input logic [7:0] op);
        is_erase_op = (op == `OP_BULK_ERASE) || (op == `OP_SECTOR_ERASE)
            || (op == `OP_SUBSECTOR_ERASE);
    endfunction : is_erase_op

    function automatic logic is_read_op(input logic [7:0] op);
        is_read_op = (op == `OP_READ_BYTES) || (op == `OP_FAST_READ)
            || (op == `OP_DUAL_READ) || (op == `OP_QUAD_READ)
            || (op == `OP_READ_ID);
    endfunction : is_read_op

    function automatic erase_scope_t scope_of(input logic [7:0] op);
        if (op == `OP_SECTOR_ERASE) begin
            scope_of = SCOPE_SECTOR;
        end else if (op == `OP_SUBSECTOR_ERASE) begin
            scope_of = SCOPE_SUBSECTOR;
        end else begin
            scope_of = SCOPE_BULK;
        end
    endfunction : scope_of

    // exact frame length an erase needs
    function automatic logic [5:0] erase_len(input logic [7:0] op, input logic four);
        if (op == `OP_BULK_ERASE) begin
            erase_len = `OPCODE_BITS;
        end else if (four) begin
            erase_len = `ADDR4_FRAME_BITS;
        end else begin
            erase_len = `ADDR3_FRAME_BITS;
        end
    endfunction : erase_len

    function automatic logic [31:0] base_of(input erase_scope_t sc, input logic [31:0] a);
        if (sc == SCOPE_SECTOR) begin
            base_of = a & `SECTOR_MASK;
        end else if (sc == SCOPE_SUBSECTOR) begin
            base_of = a & `SUBSECTOR_MASK;
        end else begin
            base_of = 32'h0000_0000;
        end
    endfunction : base_of

    function automatic logic [31:0] load_of(input erase_scope_t sc);
        if (sc == SCOPE_SECTOR) begin
            load_of = 32'(SECTOR_ERASE_CYCLES - 1);
        end else if (sc == SCOPE_SUBSECTOR) begin
            load_of = 32'(SUBSECTOR_ERASE_CYCLES - 1);
        end else begin
            load_of = 32'(WHOLE_ERASE_CYCLES - 1);
        end
    endfunction : load_of

    // frame ends on the synchronised rising edge of chip select
    assign frame_end = q.cs_s2 & ~q.cs_d;
    assign eff_addr = addr_four_byte ? frame_addr : (frame_addr & `ADDR3_MASK);

    always_comb begin
        d = q;
        d.cs_s1 = chip_select_n;
        d.cs_s2 = q.cs_s1;
        d.cs_d = q.cs_s2;
        d.start = 1'b0;
        d.commit = 1'b0;
        d.refused = 1'b0;
        case (q.state)
            ST_IDLE: begin
                if (frame_end) begin
                    if (frame_opcode == `OP_WRITE_ENABLE && frame_bits == `OPCODE_BITS) begin
                        d.wel = 1'b1;
                    end else if (frame_opcode == `OP_WRITE_DISABLE
                                 && frame_bits == `OPCODE_BITS) begin
                        d.wel = 1'b0;
                    end else if (is_erase_op(frame_opcode) && q.wel
                                 && frame_bits == erase_len(frame_opcode, addr_four_byte)) begin
                        d.state = ST_ERASE;
                        d.start = 1'b1;
                        d.wip = 1'b1;
                        d.wel = 1'b0;
                        d.scope = scope_of(frame_opcode);
                        d.base = base_of(scope_of(frame_opcode), eff_addr);
                        d.timer = load_of(scope_of(frame_opcode));
                    end
                end
            end
            ST_ERASE: begin
                if (frame_end && is_read_op(frame_opcode)) begin
                    d.refused = 1'b1;
                end
                if (q.timer == 32'h0000_0000) begin
                    d.state = ST_IDLE;
                    d.wip = 1'b0;
                    d.commit = 1'b1;
                end else begin
                    d.timer = q.timer - 32'h0000_0001;
                end
            end
            default: begin
                d.state = ST_IDLE;
                d.wip = 1'b0;
            end
        endcase
        d.active = ~q.cs_s2 | (d.state == ST_ERASE);
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            q <= RESET_STATE;
        end else begin
            q <= d;
        end
    end

    assign wip_r = q.wip;
    assign wel_r = q.wel;
    assign active_power_r = q.active;
    assign erase_start_r = q.start;
    assign erase_commit_r = q.commit;
    assign erase_scope_r = q.scope;
    assign erase_base_r = q.base;
    assign read_refused_r = q.refused;

    chk_start_needs_wel: assert property (@(posedge clk) disable iff (reset)
        erase_start_r |-> $past(wel_r) && !$past(wip_r))
        else $error("erase started without write enable");

    chk_wel_cleared: assert property (@(posedge clk) disable iff (reset)
        erase_start_r |-> !wel_r ##1 !wel_r)
        else $error("write enable latch not cleared at erase start");

    chk_busy_span: assert property (@(posedge clk) disable iff (reset)
        erase_start_r |-> wip_r throughout (##[0:1] !erase_commit_r))
        else $error("busy bit not set during erase");

    chk_commit_clears: assert property (@(posedge clk) disable iff (reset)
        erase_commit_r |-> !wip_r && $past(wip_r))
        else $error("busy bit not cleared at erase end");

    chk_start_on_rise: assert property (@(posedge clk) disable iff (reset)
        erase_start_r |-> $past(frame_end))
        else $error("erase started outside chip select rise");

    chk_bulk_length: assert property (@(posedge clk) disable iff (reset)
        erase_start_r && erase_scope_r == SCOPE_BULK
        |-> $past(frame_bits) == `OPCODE_BITS)
        else $error("bulk erase accepted with wrong frame length");

    chk_sector_align: assert property (@(posedge clk) disable iff (reset)
        erase_start_r && erase_scope_r == SCOPE_SECTOR
        |-> (erase_base_r & ~`SECTOR_MASK) == 32'h0000_0000)
        else $error("sector base not aligned");

    chk_subsector_align: assert property (@(posedge clk) disable iff (reset)
        erase_start_r && erase_scope_r == SCOPE_SUBSECTOR
        |-> (erase_base_r & ~`SUBSECTOR_MASK) == 32'h0000_0000)
        else $error("subsector base not aligned");

    chk_active_select: assert property (@(posedge clk) disable iff (reset)
        !q.cs_s2 |=> active_power_r)
        else $error("selected device not in active power");

    chk_active_busy: assert property (@(posedge clk) disable iff (reset)
        wip_r |-> active_power_r)
        else $error("standby entered during erase");

    chk_read_blocked: assert property (@(posedge clk) disable iff (reset)
        read_refused_r |-> $past(wip_r) && !erase_start_r)
        else $error("read refusal outside erase");

    chk_wip_on_start: assert property (@(posedge clk) disable iff (reset)
        erase_start_r |-> wip_r)
        else $error("busy bit not set at erase start");

    chk_busy_drop: assert property (@(posedge clk) disable iff (reset)
        $fell(wip_r) |-> erase_commit_r)
        else $error("busy bit dropped before erase end");

    chk_commit_standby: assert property (@(posedge clk) disable iff (reset)
        erase_commit_r && q.cs_s2 |=> !active_power_r)
        else $error("standby not entered after erase end");

    chk_wel_frozen: assert property (@(posedge clk) disable iff (reset)
        wip_r |-> !wel_r)
        else $error("write enable latch set during erase");

    chk_region_stable: assert property (@(posedge clk) disable iff (reset)
        wip_r && !erase_start_r
        |-> $stable(erase_scope_r) && $stable(erase_base_r))
        else $error("erase region changed during erase");

    chk_refuse_pulse: assert property (@(posedge clk) disable iff (reset)
        read_refused_r |=> !read_refused_r)
        else $error("read refusal longer than one cycle");

    chk_start_pulse: assert property (@(posedge clk) disable iff (reset)
        erase_start_r |=> !erase_start_r)
        else $error("erase start longer than one cycle");

    chk_commit_pulse: assert property (@(posedge clk) disable iff (reset)
        erase_commit_r |=> !erase_commit_r)
        else $error("erase end longer than one cycle");

    chk_bulk_base: assert property (@(posedge clk) disable iff (reset)
        erase_start_r && erase_scope_r == SCOPE_BULK
        |-> erase_base_r == 32'h0000_0000)
        else $error("whole-array erase with nonzero base");

    chk_erase_span: assert property (@(posedge clk) disable iff (reset)
        erase_start_r |-> q.timer == load_of(q.scope))
        else $error("erase timer loaded with wrong length");

    chk_short_addr: assert property (@(posedge clk) disable iff (reset)
        erase_start_r && !$past(addr_four_byte)
        |-> erase_base_r[31:24] == 8'h00)
        else $error("upper address byte used in three-byte mode");

    chk_refused_no_start: assert property (@(posedge clk) disable iff (reset)
        read_refused_r |-> wip_r || erase_commit_r)
        else $error("read refusal disturbed the erase");

    chk_wel_on_frame: assert property (@(posedge clk) disable iff (reset)
        $changed(wel_r) |-> $past(frame_end))
        else $error("write enable latch changed outside a frame end");

endmodule : serial_flash_erase_control

/* File: sim/flash_host_model.sv */
// host side of the serial link: frames opcode and address bits
`timescale 1ns/10ps

module flash_host_model (
    output logic serial_clock,
    output logic chip_select_n,
    output logic serial_data_in_line
);
    initial begin
        serial_clock = 1'b0;
        chip_select_n = 1'b0;
        serial_data_in_line = 1'b0;
        // clean rising edge arms the frame start flag
        #1 chip_select_n = 1'b1;
    end

    // link clock runs only inside a frame, 15 ns period
    task automatic send(input logic [39:0] frame, input int n);
        chip_select_n = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            serial_data_in_line = frame[i];
            #3.75 serial_clock = 1'b1;
            #7.5 serial_clock = 1'b0;
            #3.75;
        end
        chip_select_n = 1'b1;
        serial_data_in_line = ~serial_data_in_line;
    endtask : send
endmodule : flash_host_model

/* File: sim/tb_top.sv */
// self-checking bench of the erase controller
`timescale 1ns/10ps

module tb_top;
    localparam int bulk_cyc = 200;
    localparam int sect_cyc = 40;
    localparam int sub_cyc = 25;
    typedef struct {
        logic wren;
        logic four;
        logic [39:0] frame;
        int n;
        logic go;
        logic [1:0] scope;
        logic [31:0] base;
    } row_t;
    logic clk, reset, addr_four_byte;
    logic serial_clock, chip_select_n, serial_data_in_line;
    logic wip_r, wel_r, active_power_r, erase_start_r, erase_commit_r, read_refused_r;
    logic [1:0] erase_scope_r;
    logic [31:0] erase_base_r;
    int n_mismatch = 0;
    int tests_run = 0;
    int cyc;
    logic [7:0] reads [5] = '{8'h03, 8'h0B, 8'hBB, 8'hEB, 8'h9F};
    row_t rows [9] = '{
        '{1, 0, 40'h00_0000_00C7, 8, 1, 2'h0, 32'h0000_0000},
        '{1, 0, 40'h00_D812_3456, 32, 1, 2'h1, 32'h0012_0000},
        '{1, 0, 40'h00_20AB_CDEF, 32, 1, 2'h2, 32'h00AB_C000},
        '{1, 1, 40'hD8_8765_4321, 40, 1, 2'h1, 32'h8765_0000},
        '{1, 1, 40'h20_0123_4FFF, 40, 1, 2'h2, 32'h0123_4000},
        '{0, 0, 40'h00_D812_3456, 32, 0, 2'h0, 32'h0000_0000},
        '{1, 0, 40'h00_0000_C7C7, 16, 0, 2'h0, 32'h0000_0000},
        '{1, 0, 40'h00_6C09_1A2B, 31, 0, 2'h0, 32'h0000_0000},
        '{1, 1, 40'h00_D812_3456, 32, 0, 2'h0, 32'h0000_0000}
    };

    flash_host_model host (
        .serial_clock(serial_clock),
        .chip_select_n(chip_select_n),
        .serial_data_in_line(serial_data_in_line)
    );

    serial_flash_erase_control #(
        .WHOLE_ERASE_CYCLES(bulk_cyc),
        .SECTOR_ERASE_CYCLES(sect_cyc),
        .SUBSECTOR_ERASE_CYCLES(sub_cyc)
    ) dut (
        .clk(clk),
        .reset(reset),
        .serial_clock(serial_clock),
        .chip_select_n(chip_select_n),
        .serial_data_in_line(serial_data_in_line),
        .addr_four_byte(addr_four_byte),
        .wip_r(wip_r),
        .wel_r(wel_r),
        .active_power_r(active_power_r),
        .erase_start_r(erase_start_r),
        .erase_commit_r(erase_commit_r),
        .erase_scope_r(erase_scope_r),
        .erase_base_r(erase_base_r),
        .read_refused_r(read_refused_r)
    );

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic give_verdict();
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : give_verdict

    // which: 0 start, 1 commit, 2 refused, other just waits
    task automatic wait_sig(input int which, input int lim, output int found);
        logic s;
        found = -1;
        for (int i = 1; i <= lim; i++) begin
            @(posedge clk);
            #1;
            s = (which == 0) ? erase_start_r : (which == 1) ? erase_commit_r :
                (which == 2) ? read_refused_r : 1'b0;
            if (s === 1'b1) begin
                found = i;
                break;
            end
        end
    endtask : wait_sig

    task automatic write_enable();
        host.send(40'h00_0000_0006, 8);
        wait_sig(3, 6, cyc);
    endtask : write_enable

    initial begin
        #200000;
        n_mismatch++;
        give_verdict();
    end

    initial begin
        reset = 1'b1;
        addr_four_byte = 1'b0;
        repeat (3) @(posedge clk);
        #1 reset = 1'b0;
        check("power_after_reset", active_power_r, 1'b0);
        wait_sig(3, 4, cyc);
        for (int r = 0; r < 9; r++) begin
            addr_four_byte = rows[r].four;
            if (rows[r].wren) begin
                write_enable();
                check("wel_set", wel_r, 1'b1);
            end
            host.send(rows[r].frame, rows[r].n);
            wait_sig(0, 12, cyc);
            check("started", cyc >= 0, rows[r].go);
            if (rows[r].go) begin
                check("scope", erase_scope_r, rows[r].scope);
                check("base", erase_base_r, rows[r].base);
                check("busy_set", wip_r, 1'b1);
                check("wel_clear", wel_r, 1'b0);
                check("active_busy", active_power_r, 1'b1);
                wait_sig(1, bulk_cyc + 4, cyc);
                check("erase_len", cyc, rows[r].scope == 2'h0 ? bulk_cyc :
                    rows[r].scope == 2'h1 ? sect_cyc : sub_cyc);
                check("busy_clear", wip_r, 1'b0);
                wait_sig(3, 2, cyc);
                check("standby", active_power_r, 1'b0);
            end else begin
                check("idle_busy", wip_r, 1'b0);
            end
        end
        addr_four_byte = 1'b0;
        write_enable();
        host.send(40'h00_0000_0004, 8);
        wait_sig(3, 6, cyc);
        check("wel_disabled", wel_r, 1'b0);
        host.send(40'h00_0000_00C7, 8);
        wait_sig(0, 12, cyc);
        check("no_start_disabled", cyc, -1);
        write_enable();
        host.send(40'h00_0000_00C7, 8);
        wait_sig(0, 12, cyc);
        for (int k = 0; k < 5; k++) begin
            host.send({8'h00, reads[k], 24'h01_0000}, 32);
            wait_sig(2, 8, cyc);
            check("read_refused", cyc >= 0, 1'b1);
            check("busy_kept", wip_r, 1'b1);
            wait_sig(3, 2, cyc);
        end
        write_enable();
        check("wel_busy", wel_r, 1'b0);
        wait_sig(1, bulk_cyc, cyc);
        check("bulk_done", cyc >= 0, 1'b1);
        write_enable();
        host.send(40'h00_D8FF_FFFF, 32);
        wait_sig(0, 12, cyc);
        reset = 1'b1;
        repeat (3) @(posedge clk);
        #1 reset = 1'b0;
        check("reset_busy", wip_r, 1'b0);
        check("reset_wel", wel_r, 1'b0);
        check("reset_base", erase_base_r, 32'h0000_0000);
        wait_sig(1, sect_cyc + 4, cyc);
        check("no_commit", cyc, -1);
        give_verdict();
    end
endmodule : tb_top
